//--- design/tape_block_formatter.v
// Tape block formatter: write framing, flux coding, read deskew and block checks.
`timescale 1ns/10ps
`include "tape_consts.vh"

module tape_block_formatter #(
	parameter [7:0] CRC_POLY = `CRC_POLY,
	parameter [11:0] ID_CELLS = `ID_BURST_CELLS
)(
	input wire core_clk,
	input wire resetn,
	input wire ce,
	input wire [1:0] fmt,
	input wire par_odd,
	input wire wr_valid,
	input wire [7:0] wr_data,
	input wire wr_last,
	output wire wr_ready,
	input wire cmd_tm,
	input wire cmd_id,
	output wire cmd_ready,
	output wire wr_busy,
	output wire [8:0] flux,
	output wire [8:0] wbus_char,
	output wire wbus_strobe,
	output wire wr_done,
	input wire [8:0] rd_pulse,
	input wire [8:0] rd_bit,
	input wire [8:0] rd_rev,
	input wire rd_end,
	output wire rd_valid,
	output wire [8:0] rd_char,
	output wire blk_end,
	output wire blk_err,
	output wire tm_found
);

// ----------------------------------------
// Timing
// ----------------------------------------
localparam integer CELL_C = (`WR_CELL_NS * `CLK_MHZ + 999) / 1000;
localparam integer GAP_C = ((`SKEW_GATE_NS + `SPACING_MARGIN_NS) * `CLK_MHZ + 999) / 1000;
localparam integer SLOT_C = (CELL_C > GAP_C) ? CELL_C : GAP_C;
localparam integer HALF_C = (SLOT_C + 1) / 2;
localparam integer RGATE_C = (`RD_GATE_NS * `CLK_MHZ + 999) / 1000;
localparam integer PEGATE_C = (CELL_C * `PE_SKEW_TENTHS + 9) / 10;
localparam integer HOLD_C = (`SPACING_MARGIN_NS * `CLK_MHZ + 999) / 1000;
localparam [31:0] HALF_W = HALF_C - 1;
localparam [31:0] RGATE_W = RGATE_C - 1;
localparam [31:0] PEGATE_W = PEGATE_C - 1;
localparam [31:0] HOLD_W = HOLD_C;
localparam [15:0] HALF_END = HALF_W[15:0];
localparam [15:0] RGATE_END = RGATE_W[15:0];
localparam [15:0] PEGATE_END = PEGATE_W[15:0];
localparam [15:0] HOLD_LOAD = HOLD_W[15:0];

localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_ID = 3'h1;
localparam [2:0] S_PRE = 3'h2;
localparam [2:0] S_DATA = 3'h3;
localparam [2:0] S_POST = 3'h4;
localparam [2:0] S_CHK = 3'h5;
localparam [2:0] S_TMB = 3'h6;
localparam [2:0] S_TMC = 3'h7;

localparam [1:0] K_BLANK = 2'h0;
localparam [1:0] K_CHAR = 2'h1;
localparam [1:0] K_HALFB = 2'h2;
localparam [1:0] K_CELLB = 2'h3;

// ----------------------------------------
// Bit-space ticks
// ----------------------------------------
reg [15:0] half_cnt_ff;
reg phase_ff;
wire half_tick = (half_cnt_ff == HALF_END);
wire cell_start = half_tick & phase_ff;

// One cell is at least the skew gate fall plus the margin long.
always @(posedge core_clk)
begin
	if (!resetn)
	begin
		half_cnt_ff <= 16'h0000;
		phase_ff <= 1'b0;
	end
	else if (ce)
	begin
		if (half_tick)
		begin
			half_cnt_ff <= 16'h0000;
			phase_ff <= ~phase_ff;
		end
		else
			half_cnt_ff <= half_cnt_ff + 16'h0001;
	end
end

// ----------------------------------------
// Write framing
// ----------------------------------------
reg [2:0] state_ff;
reg [11:0] cnt_ff;
reg [1:0] wfmt_ff;
reg [7:0] crc_ff;
reg [8:0] lrc_ff;
reg odd_ff;
reg tm_ff;
reg [1:0] kind_ff;
reg [8:0] cell_char_ff;
reg [8:0] flux_ff;
reg [8:0] wbus_char_ff;
reg wbus_strobe_ff;
reg wr_done_ff;
reg [2:0] nxt_state;
reg [11:0] nxt_cnt;
reg [7:0] nxt_crc;
reg [8:0] nxt_lrc;
reg nxt_odd;
reg nxt_tm;
reg [1:0] kind;
reg [8:0] emit;
reg done;
reg [8:0] nxt_flux;
wire [7:0] crc_wr;

wire w_pe = (wfmt_ff == `FMT_PE);
wire w_n7 = (wfmt_ff == `FMT_NRZI7);
wire [8:0] char9 = {~^wr_data, wr_data};
wire c7 = par_odd ? ~^wr_data[5:0] : ^wr_data[5:0];
wire [8:0] char7 = {c7, 2'b00, wr_data[5:0]};
wire [8:0] wr_char = w_n7 ? char7 : char9;
wire [8:0] crc_char = {^crc_ff ^ ~odd_ff, crc_ff};
wire [8:0] lrc9_char = {~^lrc_ff[7:0], lrc_ff[7:0]};
wire tm7_c = par_odd ? ~^`TM7_DATA : ^`TM7_DATA;
wire [8:0] tm_char = w_n7 ? {tm7_c, 2'b00, `TM7_DATA} : `TM9_CHAR;

assign wr_ready = ce & cell_start & (state_ff == S_DATA);
assign cmd_ready = ce & cell_start & (state_ff == S_IDLE);
assign wr_busy = (state_ff != S_IDLE);

crc_step #(
	.POLY(CRC_POLY)
) u_crc_wr (
	.crc_in(crc_ff),
	.char_in(wr_data),
	.crc_out(crc_wr)
);

always @*
begin
	nxt_state = state_ff;
	nxt_cnt = cnt_ff + 12'h001;
	nxt_crc = crc_ff;
	nxt_lrc = lrc_ff;
	nxt_odd = odd_ff;
	nxt_tm = tm_ff;
	kind = K_BLANK;
	emit = 9'h000;
	done = 1'b0;
	case (state_ff)
	S_IDLE:
	begin
		nxt_cnt = 12'h000;
		nxt_crc = 8'h00;
		nxt_lrc = 9'h000;
		nxt_odd = 1'b0;
		nxt_tm = 1'b0;
		if (cmd_id && (fmt == `FMT_PE))
			nxt_state = S_ID;
		else if (cmd_tm)
			nxt_state = (fmt == `FMT_PE) ? S_TMB : S_TMC;
		else if (wr_valid)
			nxt_state = (fmt == `FMT_PE) ? S_PRE : S_DATA;
	end
	S_ID:
	begin
		kind = K_CELLB;
		emit = `ID_MASK;
		if (cnt_ff == ID_CELLS - 12'h001)
		begin
			nxt_state = S_IDLE;
			done = 1'b1;
		end
	end
	S_TMB:
	begin
		kind = K_HALFB;
		emit = `PE_TM_MASK;
		if (cnt_ff == `PE_TM_CELLS - 12'h001)
		begin
			nxt_state = S_IDLE;
			done = 1'b1;
		end
	end
	S_PRE:
	begin
		kind = K_CHAR;
		emit = (cnt_ff == `PE_SYNC_ZEROS) ? `ALL_ONES : 9'h000;
		if (cnt_ff == `PE_SYNC_ZEROS)
			nxt_state = S_DATA;
	end
	S_DATA:
	begin
		nxt_cnt = 12'h001;
		if (wr_valid)
		begin
			kind = K_CHAR;
			emit = wr_char;
			nxt_crc = crc_wr;
			nxt_lrc = lrc_ff ^ wr_char;
			nxt_odd = ~odd_ff;
			if (wr_last)
			begin
				nxt_state = w_pe ? S_POST : S_CHK;
				nxt_cnt = w_pe ? 12'h000 : 12'h001;
			end
		end
	end
	S_POST:
	begin
		kind = K_CHAR;
		emit = (cnt_ff == 12'h000) ? `ALL_ONES : 9'h000;
		if (cnt_ff == `PE_SYNC_ZEROS)
		begin
			nxt_state = S_IDLE;
			done = 1'b1;
		end
	end
	S_CHK:
	begin
		if (w_n7 && (cnt_ff == `LRC7_SPACE))
		begin
			kind = K_CHAR;
			emit = lrc_ff;
			nxt_state = S_IDLE;
			done = 1'b1;
		end
		else if (!w_n7 && !tm_ff && (cnt_ff == `CRC_SPACE))
		begin
			kind = K_CHAR;
			emit = crc_char;
			nxt_lrc = lrc_ff ^ crc_char;
		end
		else if (!w_n7 && (cnt_ff == `LRC9_SPACE))
		begin
			kind = K_CHAR;
			emit = lrc9_char;
			nxt_state = S_IDLE;
			done = 1'b1;
		end
	end
	S_TMC:
	begin
		kind = K_CHAR;
		emit = tm_char;
		nxt_lrc = tm_char;
		nxt_tm = 1'b1;
		nxt_state = S_CHK;
		nxt_cnt = 12'h001;
	end
	default:
		nxt_state = S_IDLE;
	endcase
end

// Burst cells toggle their mask tracks and keep all other tracks erased.
always @*
begin
	nxt_flux = flux_ff;
	if (phase_ff)
	begin
		case (kind)
		K_CHAR:
			nxt_flux = w_pe ? ~emit : flux_ff ^ emit;
		K_BLANK:
			nxt_flux = w_pe ? `ALL_ONES : flux_ff;
		default:
			nxt_flux = ((flux_ff ^ emit) & emit) | ~emit;
		endcase
	end
	else
	begin
		case (kind_ff)
		K_CHAR:
			nxt_flux = w_pe ? cell_char_ff : flux_ff;
		K_HALFB:
			nxt_flux = ((flux_ff ^ cell_char_ff) & cell_char_ff) | ~cell_char_ff;
		default:
			nxt_flux = flux_ff;
		endcase
	end
end

always @(posedge core_clk)
begin
	if (!resetn)
	begin
		state_ff <= S_IDLE;
		cnt_ff <= 12'h000;
		wfmt_ff <= `FMT_NRZI9;
		crc_ff <= 8'h00;
		lrc_ff <= 9'h000;
		odd_ff <= 1'b0;
		tm_ff <= 1'b0;
		kind_ff <= K_BLANK;
		cell_char_ff <= 9'h000;
		flux_ff <= `ALL_ONES;
		wbus_char_ff <= 9'h000;
		wbus_strobe_ff <= 1'b0;
		wr_done_ff <= 1'b0;
	end
	else if (ce)
	begin
		wbus_strobe_ff <= 1'b0;
		wr_done_ff <= 1'b0;
		if (state_ff == S_IDLE)
			wfmt_ff <= fmt;
		if (half_tick)
			flux_ff <= nxt_flux;
		if (cell_start)
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			crc_ff <= nxt_crc;
			lrc_ff <= nxt_lrc;
			odd_ff <= nxt_odd;
			tm_ff <= nxt_tm;
			kind_ff <= kind;
			cell_char_ff <= emit;
			wr_done_ff <= done;
			if (kind == K_CHAR)
			begin
				wbus_char_ff <= emit;
				wbus_strobe_ff <= 1'b1;
			end
		end
	end
end

assign flux = flux_ff;
assign wbus_char = wbus_char_ff;
assign wbus_strobe = wbus_strobe_ff;
assign wr_done = wr_done_ff;

// ----------------------------------------
// Read deskew
// ----------------------------------------
reg gate_ff;
reg [15:0] gcnt_ff;
reg [15:0] hold_ff;
wire r_pe = (fmt == `FMT_PE);
wire [8:0] pval = r_pe ? rd_bit : `ALL_ONES;
wire gate_open = ~gate_ff & (hold_ff == 16'h0000) & (|rd_pulse);
wire char_done = gate_ff & (gcnt_ff == (r_pe ? PEGATE_END : RGATE_END));
wire [8:0] cap_w;
wire [8:0] hit_w;
wire [8:0] quiet_w;

genvar t;
generate
	for (t = 0; t < 9; t = t + 1)
	begin : g_track
		reg cap_ff;
		reg [6:0] rev_ff;
		assign cap_w[t] = cap_ff | (rd_pulse[t] & pval[t]);
		assign hit_w[t] = rev_ff[6];
		assign quiet_w[t] = (rev_ff == 7'h00);
		always @(posedge core_clk)
		begin
			if (!resetn)
			begin
				cap_ff <= 1'b0;
				rev_ff <= 7'h00;
			end
			else if (ce)
			begin
				if (char_done)
					cap_ff <= 1'b0;
				else if (rd_pulse[t] & (gate_ff | gate_open))
					cap_ff <= pval[t];
				if (rd_end)
					rev_ff <= 7'h00;
				else if (rd_rev[t] && (rev_ff != `PE_TM_DETECT))
					rev_ff <= rev_ff + 7'h01;
			end
		end
	end
endgenerate

// After each character the gate stays shut for the margin time.
always @(posedge core_clk)
begin
	if (!resetn)
	begin
		gate_ff <= 1'b0;
		gcnt_ff <= 16'h0000;
		hold_ff <= 16'h0000;
	end
	else if (ce)
	begin
		if (char_done)
		begin
			gate_ff <= 1'b0;
			hold_ff <= HOLD_LOAD;
		end
		else if (gate_open)
		begin
			gate_ff <= 1'b1;
			// The opening cycle counts as the first gate cycle, so in the NRZI formats gate and hold-off
			// together span exactly one cell and back-to-back characters are taken.
			gcnt_ff <= 16'h0001;
		end
		else if (gate_ff)
			gcnt_ff <= gcnt_ff + 16'h0001;
		if (!char_done && (hold_ff != 16'h0000))
			hold_ff <= hold_ff - 16'h0001;
	end
end

// ----------------------------------------
// Read checks
// ----------------------------------------
reg [1:0] rpe_ff;
reg [8:0] h1_ff;
reg [8:0] h2_ff;
reg [15:0] n_ff;
reg [7:0] rcrc_ff;
reg [8:0] rlrc_ff;
reg pbad_ff;
reg rd_valid_ff;
reg [8:0] rd_char_ff;
reg blk_end_ff;
reg blk_err_ff;
reg tm_found_ff;
wire [7:0] crc_rd;
wire r_n7 = (fmt == `FMT_NRZI7);
wire [15:0] age = r_pe ? 16'h0000 : (r_n7 ? 16'h0001 : 16'h0002);
wire deliver = char_done & (r_pe ? ((rpe_ff == 2'h1) && (cap_w != 9'h000)) : 1'b1);
wire [8:0] aged = r_pe ? cap_w : (r_n7 ? h1_ff : h2_ff);
wire aged_ok = deliver & (n_ff >= age);
wire pwrong = r_n7 ? ((^{aged[8], aged[5:0]}) != par_odd) : ~^aged;
wire tm_pe = ((((hit_w & `ZONE1_MASK) == `ZONE1_MASK) | ((hit_w & `ZONE2_MASK) == `ZONE2_MASK))
	& ((quiet_w & `ZONE3_MASK) == `ZONE3_MASK));
wire tm7 = (h1_ff == h2_ff) & (h1_ff[5:0] == `TM7_DATA);
wire tm_nrzi = (n_ff == 16'h0002) & (h1_ff == h2_ff) & (r_n7 ? tm7 : (h1_ff == `TM9_CHAR));
wire crc_bad = (h2_ff[7:0] != rcrc_ff) | ((^h2_ff) != ~n_ff[0]);
wire lrc_bad = r_n7 ? (rlrc_ff != 9'h000) : ((rlrc_ff[7:0] != 8'h00) | ~^h1_ff);
wire short_blk = (n_ff <= age);
wire nrzi_bad = tm_nrzi ? 1'b0 : (short_blk | lrc_bad | (~r_n7 & crc_bad));

crc_step #(
	.POLY(CRC_POLY)
) u_crc_rd (
	.crc_in(rcrc_ff),
	.char_in(aged[7:0]),
	.crc_out(crc_rd)
);

always @(posedge core_clk)
begin
	if (!resetn)
	begin
		rpe_ff <= 2'h0;
		h1_ff <= 9'h000;
		h2_ff <= 9'h000;
		n_ff <= 16'h0000;
		rcrc_ff <= 8'h00;
		rlrc_ff <= 9'h000;
		pbad_ff <= 1'b0;
		rd_valid_ff <= 1'b0;
		rd_char_ff <= 9'h000;
		blk_end_ff <= 1'b0;
		blk_err_ff <= 1'b0;
		tm_found_ff <= 1'b0;
	end
	else if (ce)
	begin
		rd_valid_ff <= deliver;
		blk_end_ff <= 1'b0;
		tm_found_ff <= 1'b0;
		if (rd_end)
		begin
			blk_end_ff <= 1'b1;
			blk_err_ff <= pbad_ff | (r_pe ? 1'b0 : nrzi_bad);
			tm_found_ff <= r_pe ? tm_pe : tm_nrzi;
			rpe_ff <= 2'h0;
			n_ff <= 16'h0000;
			rcrc_ff <= 8'h00;
			rlrc_ff <= 9'h000;
			pbad_ff <= 1'b0;
		end
		else if (char_done)
		begin
			if (rpe_ff == 2'h0 && cap_w == `ALL_ONES)
				rpe_ff <= 2'h1;
			else if (rpe_ff == 2'h1 && cap_w == 9'h000)
				rpe_ff <= 2'h2;
			if (deliver)
			begin
				rd_char_ff <= cap_w;
				h1_ff <= cap_w;
				h2_ff <= h1_ff;
				n_ff <= n_ff + 16'h0001;
				rlrc_ff <= rlrc_ff ^ cap_w;
			end
			if (aged_ok)
			begin
				rcrc_ff <= crc_rd;
				pbad_ff <= pbad_ff | pwrong;
			end
		end
	end
end

assign rd_valid = rd_valid_ff;
assign rd_char = rd_char_ff;
assign blk_end = blk_end_ff;
assign blk_err = blk_err_ff;
assign tm_found = tm_found_ff;

endmodule

//--- pkg/tape_consts.vh
// Constants for the tape block formatter: formats, characters, masks and timing.
//
// Behaviour
// - Nine-track bytes get parity bit set when data ones are even; odd overall.
// - Nine-track NRZI cyclic check character goes four bit spaces after last data.
// - Cyclic check character parity is even for odd byte count, odd otherwise.
// - NRZI longitudinal check makes every track's one count even over the block, except the nine-track parity track.
// - Nine-track NRZI longitudinal check character goes eight bit spaces after data.
// - Nine-track NRZI longitudinal check character always has odd parity.
// - Longitudinal check character is deskewed by the same logic as data.
// - Nine-track NRZI tape mark: tracks 3, 6, 7 character, identical check eight spaces on.
// - Nine-track NRZI tape mark carries no cyclic check character.
// - Seven-track tape mark: tracks 8, 4, 2, 1 character, identical check four spaces on.
// - Seven-track check bit set when data lacks the selected odd or even parity.
// - Seven-track longitudinal check follows last character or tape mark by four spaces.
// - Phase encoding: mid-cell transition toward erased means one, away means zero.
// - Phase-encoded block opens with 40 zero characters, one all-ones, then data.
// - Phase-encoded block closes with one all-ones character then 40 zero characters.
// - Phase-encoded tape mark: 80 or more double-rate reversals on P,0,2,5,6,7.
// - Tape mark read when P/0/5 or 2/6/7 show 64 reversals, 1/3/4 erased.
// - Identification burst at load point toggles the parity track only.
// - NRZI writing toggles a track for each one and holds it for zero.
// - Written bytes are spaced at least skew gate fall plus 1 usec.
// - Read characters are spaced at least character gate end plus 1 usec.
// - Phase-encoded deskew tolerates up to 1.8 bit times of track skew.
`ifndef TAPE_CONSTS_VH
`define TAPE_CONSTS_VH

`define FMT_NRZI9 2'h0
`define FMT_PE 2'h1
`define FMT_NRZI7 2'h2

`define CLK_MHZ 100
`define WR_CELL_NS 2000
`define SKEW_GATE_NS 1500
`define SPACING_MARGIN_NS 1000
`define RD_GATE_NS 1500
`define PE_SKEW_TENTHS 18

`define CRC_SPACE 12'h004
`define LRC9_SPACE 12'h008
`define LRC7_SPACE 12'h004
`define PE_SYNC_ZEROS 12'h028
`define PE_TM_CELLS 12'h028
`define ID_BURST_CELLS 12'haa0
`define PE_TM_DETECT 7'h40

`define CRC_POLY 8'hb5
`define ALL_ONES 9'h1ff
`define TM9_CHAR 9'h0c8
`define TM7_DATA 6'h0f
`define ZONE1_MASK 9'h121
`define ZONE2_MASK 9'h0c4
`define ZONE3_MASK 9'h01a
`define PE_TM_MASK 9'h1e5
`define ID_MASK 9'h100

`endif

//--- design/crc_step.v
// One step of the cyclic check character generator.
`timescale 1ns/10ps
`include "tape_consts.vh"

module crc_step #(
	parameter [7:0] POLY = `CRC_POLY
)(
	input wire [7:0] crc_in,
	input wire [7:0] char_in,
	output wire [7:0] crc_out
);

// The feedback polynomial is a parameter so the system can supply its own.
assign crc_out = {crc_in[6:0], 1'b0} ^ (crc_in[7] ? POLY : 8'h00) ^ char_in;

endmodule

//--- verification/tape_block_formatter_asserts.sv
// Port assertions for the tape block formatter.
`timescale 1ns/10ps
`include "tape_consts.vh"
module tape_block_formatter_chk (
	input wire core_clk,
	input wire resetn,
	input wire [1:0] fmt,
	input wire par_odd,
	input wire wr_valid,
	input wire [7:0] wr_data,
	input wire wr_ready,
	input wire cmd_tm,
	input wire cmd_id,
	input wire cmd_ready,
	input wire [8:0] flux,
	input wire [8:0] wbus_char,
	input wire wbus_strobe,
	input wire wr_done,
	input wire rd_end,
	input wire blk_end,
	input wire tm_found
);
default clocking @(posedge core_clk);
endclocking
default disable iff (!resetn);
// Track a PE burst or PE tape mark from its acceptance to its closing pulse.
logic id_on = 1'b0;
logic tm_on = 1'b0;
always @(posedge core_clk)
begin
	if (!resetn || wr_done)
	begin
		id_on <= 1'b0;
		tm_on <= 1'b0;
	end
	else if (cmd_ready && fmt == `FMT_PE)
	begin
		id_on <= cmd_id;
		tm_on <= cmd_tm && !cmd_id;
	end
end
chk_byte_parity: assert property (
	wr_ready && wr_valid && fmt != `FMT_NRZI7 |=> wbus_strobe &&
	wbus_char == {~^$past(wr_data), $past(wr_data)})
	else $error("written byte or its parity bit is wrong");
chk_seven_parity: assert property (
	wr_ready && wr_valid && fmt == `FMT_NRZI7 |=> wbus_char[7:6] == 2'b00 &&
	wbus_char[8] == (^wbus_char[5:0] ^ par_odd))
	else $error("seven track check bit is wrong");
chk_nrzi_toggle: assert property (
	fmt != `FMT_PE && flux != $past(flux) |-> (flux ^ $past(flux)) == wbus_char)
	else $error("flux toggles do not match the character ones");
chk_char_gap: assert property (
	wbus_strobe |=> !wbus_strobe [*8])
	else $error("characters written too close together");
chk_lrc_odd: assert property (
	fmt == `FMT_NRZI9 && wr_done |-> wbus_strobe && (^wbus_char))
	else $error("closing check character lacks odd parity");
chk_end_follow: assert property (
	rd_end |=> blk_end)
	else $error("block end not reported after gap");
chk_mark_with_end: assert property (
	tm_found |-> blk_end)
	else $error("tape mark flagged outside block end");
chk_id_erased: assert property (
	id_on |-> flux[7:0] == 8'hff)
	else $error("data track disturbed during identification burst");
chk_mark_erased: assert property (
	tm_on |-> (flux & `ZONE3_MASK) == `ZONE3_MASK)
	else $error("erased tracks disturbed during tape mark");
endmodule
bind tape_block_formatter tape_block_formatter_chk i_chk (.core_clk, .resetn, .fmt, .par_odd,
	.wr_valid, .wr_data, .wr_ready, .cmd_tm, .cmd_id, .cmd_ready, .flux, .wbus_char,
	.wbus_strobe, .wr_done, .rd_end, .blk_end, .tm_found);

//--- verification/drive_model.sv
// Tape drive model: plays written flux back as read pulses and closes each block.
`timescale 1ns/10ps
`include "tape_consts.vh"
module drive_model (
	input wire core_clk,
	input wire [1:0] fmt,
	input wire [8:0] flux,
	input wire wr_done,
	input wire drop,
	output logic [8:0] rd_pulse,
	output logic [8:0] rd_bit,
	output logic [8:0] rd_rev,
	output logic rd_end
);
logic [8:0] last = 9'h1ff;
int gap = 0;
initial {rd_pulse, rd_bit, rd_rev, rd_end} = '0;
// The gap pulse comes well after the last character so it never meets a close.
always @(posedge core_clk)
begin
	last <= flux;
	rd_pulse <= (fmt == `FMT_PE) ? 9'h000 : (flux ^ last) & ~{8'h00, drop};
	rd_rev <= (fmt == `FMT_PE) ? flux ^ last : 9'h000;
	rd_bit <= rd_bit + 9'h001;
	rd_end <= (gap == 1);
	gap <= wr_done ? 500 : (gap > 0 ? gap - 1 : 0);
end
endmodule

//--- verification/tape_block_formatter_tb_top.sv
// Testbench for the tape block formatter: blocks, marks, burst and loopback reads.
`timescale 1ns/10ps
`include "tape_consts.vh"
module tape_block_formatter_tb_top;
localparam CELL = 250;
logic core_clk = 0, resetn = 0, ce = 1, par_odd = 0, wr_valid = 0, wr_last = 0;
logic cmd_tm = 0, cmd_id = 0, drop = 0, tm_seen = 0;
logic [1:0] fmt = `FMT_NRZI9;
logic [7:0] wr_data = 8'h00;
logic [8:0] last_flux = 9'h1ff;
wire wr_ready, cmd_ready, wr_busy, wbus_strobe, wr_done, rd_end, rd_valid;
wire blk_end, blk_err, tm_found;
wire [8:0] flux, wbus_char, rd_pulse, rd_bit, rd_rev, rd_char;
int err_total = 0, n_compared = 0, cyc = 0;
int tog[9];
int qt[$];
logic [8:0] q[$], rq[$];
tape_block_formatter #(.ID_CELLS(12'h004)) i_dut (.core_clk(core_clk), .resetn(resetn),
	.ce(ce), .fmt(fmt), .par_odd(par_odd), .wr_valid(wr_valid), .wr_data(wr_data),
	.wr_last(wr_last), .wr_ready(wr_ready), .cmd_tm(cmd_tm), .cmd_id(cmd_id),
	.cmd_ready(cmd_ready), .wr_busy(wr_busy), .flux(flux), .wbus_char(wbus_char),
	.wbus_strobe(wbus_strobe), .wr_done(wr_done), .rd_pulse(rd_pulse), .rd_bit(rd_bit),
	.rd_rev(rd_rev), .rd_end(rd_end), .rd_valid(rd_valid), .rd_char(rd_char),
	.blk_end(blk_end), .blk_err(blk_err), .tm_found(tm_found));
drive_model i_drive (.core_clk(core_clk), .fmt(fmt), .flux(flux), .wr_done(wr_done),
	.drop(drop), .rd_pulse(rd_pulse), .rd_bit(rd_bit), .rd_rev(rd_rev), .rd_end(rd_end));
always #5 core_clk = ~core_clk;
always @(posedge core_clk)
begin
	cyc <= cyc + 1;
	last_flux <= flux;
	for (int i = 0; i < 9; i++)
		if (flux[i] !== last_flux[i])
			tog[i] <= tog[i] + 1;
	if (wbus_strobe)
	begin
		q.push_back(wbus_char);
		qt.push_back(cyc);
	end
	if (rd_valid)
		rq.push_back(rd_char);
end
task chk(input logic [31:0] seen, input logic [31:0] exp);
	n_compared++;
	if (seen !== exp)
	begin
		err_total++;
		$display("Error at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
task wrap_up;
	$display("Compared %0d, mismatches %0d", n_compared, err_total);
	if (err_total == 0 && n_compared > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
task clr;
	q = {};
	qt = {};
	rq = {};
	foreach (tog[i])
		tog[i] = 0;
endtask
task put_byte(input logic [7:0] d, input logic lst);
	int k;
	k = 0;
	wr_valid = 1;
	wr_data = d;
	wr_last = lst;
	do @(negedge core_clk); while (!wr_ready && ++k < 20000);
	@(posedge core_clk);
	#1;
	chk(k < 20000, 1);
endtask
task cmd(input logic tm, input logic id);
	int k;
	k = 0;
	cmd_tm = tm;
	cmd_id = id;
	do @(negedge core_clk); while (!cmd_ready && ++k < 600);
	@(posedge core_clk);
	#1;
	cmd_tm = 0;
	cmd_id = 0;
	chk(k < 600, 1);
endtask
task wait_end;
	int k;
	k = 0;
	do @(negedge core_clk); while (!blk_end && ++k < 30000);
	tm_seen = tm_found;
	@(posedge core_clk);
	#1;
	chk(k < 30000, 1);
endtask
task t_nrzi9_pair;
	clr;
	put_byte(8'h03, 0);
	put_byte(8'h07, 1);
	chk(wr_busy, 1);
	wr_valid = 0;
	wait_end;
	chk(wr_busy, 0);
	chk(tm_seen, 0);
	chk(q.size(), 4);
	chk(q[0], 9'h103);
	chk(q[1], 9'h007);
	chk(qt[2] - qt[1], 4 * CELL);
	chk(^q[2], 1);
	chk(qt[3] - qt[1], 8 * CELL);
	chk(q[3], 9'h105);
	chk(rq.size(), 4);
	chk(rq[0], 9'h103);
	chk(rq[3], 9'h105);
	chk(blk_err, 0);
	clr;
	drop = 1;
	put_byte(8'h81, 1);
	wr_valid = 0;
	wait_end;
	drop = 0;
	chk(q[0], 9'h181);
	chk(^q[1], 0);
	chk(blk_err, 1);
	clr;
	cmd(1, 0);
	wait_end;
	chk(q.size(), 2);
	chk(q[0], `TM9_CHAR);
	chk(q[1], `TM9_CHAR);
	chk(qt[1] - qt[0], 8 * CELL);
	chk(rq[1], `TM9_CHAR);
	chk(tm_seen, 1);
endtask
task t_seven;
	fmt = `FMT_NRZI7;
	par_odd = 1;
	clr;
	cmd(1, 0);
	// Freeze for 100 cycles between the mark character and its check character.
	repeat (300) @(posedge core_clk);
	#1;
	ce = 0;
	repeat (100) @(posedge core_clk);
	#1;
	ce = 1;
	wait_end;
	chk(q[0], 9'h10f);
	chk(q[1], 9'h10f);
	chk(qt[1] - qt[0], 4 * CELL + 100);
	chk(tm_seen, 1);
	par_odd = 0;
	clr;
	put_byte(8'h07, 1);
	wr_valid = 0;
	wait_end;
	chk(q[0], 9'h107);
	chk(q[1], 9'h107);
	chk(qt[1] - qt[0], 4 * CELL);
	chk(blk_err, 0);
endtask
task t_phase;
	fmt = `FMT_PE;
	clr;
	put_byte(8'h5a, 1);
	wr_valid = 0;
	wait_end;
	chk(q.size(), 83);
	for (int i = 0; i < 83; i++)
		chk(q[i], (i == 40 || i == 42) ? 9'h1ff : (i == 41 ? 9'h15a : 9'h000));
	chk(qt[41] - qt[40], CELL);
	chk(qt[42] - qt[41], CELL);
	chk(tm_seen, 0);
	clr;
	cmd(1, 0);
	wait_end;
	for (int i = 0; i < 9; i++)
		chk(((`PE_TM_MASK >> i) & 9'h001) ? tog[i] >= 80 : tog[i] == 0, 1);
	chk(tm_seen, 1);
	clr;
	cmd(0, 1);
	wait_end;
	chk(tog[8], 4);
	for (int i = 0; i < 8; i++)
		chk(tog[i], 0);
endtask
initial
begin
	#900000;
	err_total++;
	wrap_up;
end
initial
begin
	foreach (tog[i])
		tog[i] = 0;
	repeat (4) @(posedge core_clk);
	#1;
	resetn = 1;
	t_nrzi9_pair;
	t_seven;
	t_phase;
	wrap_up;
end
endmodule
